// ==== core/secl_defines.vh ====
/*
 * constants of the serial configuration loader: memory opcodes, image
 * layout, serial clock timing, address mode codes.
 * assumes a 200 MHz reference clock and a mode 0 serial memory.
 */
`ifndef SECL_DEFINES_VH
`define SECL_DEFINES_VH

// memory instruction opcodes
`define SECL_OP_READ      8'h03
`define SECL_OP_WRITE     8'h02
`define SECL_OP_WREN      8'h06
`define SECL_OP_RDSR      8'h05
// opcode bit that carries address bit 8 in nine-bit mode
`define SECL_OP_A8_POS    3

// image layout
`define SECL_IMG_ID       16'h0000
`define SECL_IMG_CNT      16'h0002
`define SECL_IMG_REC      16'h0004
`define SECL_REC_LAST     3'h5
`define SECL_REC_BYTES    17'h00006

// serial clock: 120 ns period (12 cycles per half), about 8.3 MHz
`define SECL_REF_MHZ      200
`define SECL_SCK_HALF_NS  64
`define SECL_SCK_HALF_CYC ((`SECL_SCK_HALF_NS * `SECL_REF_MHZ) / 1000)

// detected address mode
`define SECL_MODE_NONE    2'h0
`define SECL_MODE_9       2'h1
`define SECL_MODE_16      2'h2

// record buffer
`define SECL_FIFO_W       48
`define SECL_FIFO_D       16
`define SECL_FIFO_AW      4

`endif

// ==== core/secl_fifo.v ====
/*
 * flip-flop FIFO with valid/ready on both ends, width and depth set by
 * parameters. assumes one clock, async active-high reset; depth is a
 * power of two matching the pointer width.
 */
`timescale 1ns/10ps
module secl_fifo #(
   parameter W  = 48,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire          ref_clk,
   input  wire          rst,
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);
   reg  [W-1:0] mem_r [0:D-1];  // storage
   reg  [AW-1:0] wp_r;          // write index
   reg  [AW-1:0] rp_r;          // read index
   reg  [AW:0]   cnt_r;         // fill level, one bit wider for full
   wire          push;
   wire          pop;

   assign in_ready  = (cnt_r != D);
   assign out_valid = (cnt_r != 0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointers and level; storage itself needs no reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wp_r <= wp_r + 1'b1;
         if (pop)
            rp_r <= rp_r + 1'b1;
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   // data write
   always @(posedge ref_clk) begin
      if (push)
         mem_r[wp_r] <= in_data;
   end
endmodule

// ==== core/secl_shift.v ====
/*
 * byte shifter for a mode 0 serial memory: makes the serial clock from
 * the reference clock, shifts one byte out and one in per request, and
 * owns the chip select. assumes sdi is already synchronised.
 */
`timescale 1ns/10ps
`include "secl_defines.vh"
module secl_shift (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       go,        // start a byte, taken when rdy
   input  wire [7:0] tx,        // byte to send, msb first
   input  wire       last,      // drop select after this byte
   input  wire       sdi,       // synchronised memory output
   output wire       rdy,       // idle, may take go
   output reg        done_r,    // one-cycle pulse, byte complete
   output reg  [7:0] rx_r,      // received byte
   output reg        sck_r,     // serial memory clock
   output reg        sdo_r,     // serial output to memory
   output reg        csn_r      // chip select, active low
);
   localparam E_IDLE = 2'h0;
   localparam E_LO   = 2'h1;
   localparam E_HI   = 2'h2;
   localparam E_CSH  = 2'h3;

   reg [1:0] st_r;   // shifter state
   reg [4:0] div_r;  // half period counter
   reg [2:0] bit_r;  // bits done
   reg [7:0] sh_r;   // outgoing shift
   reg       lst_r;  // last byte of instruction
   wire      half;
   wire      early;  // one cycle before half

   assign rdy   = (st_r == E_IDLE);
   assign half  = ({27'h0, div_r} == (`SECL_SCK_HALF_CYC - 1));
   assign early = ({27'h0, div_r} == (`SECL_SCK_HALF_CYC - 2));

   // clock phases, bit shifting and select timing
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r   <= E_IDLE;
         div_r  <= 5'h00;
         bit_r  <= 3'h0;
         sh_r   <= 8'h00;
         lst_r  <= 1'b0;
         done_r <= 1'b0;
         rx_r   <= 8'h00;
         sck_r  <= 1'b0;
         sdo_r  <= 1'b0;
         csn_r  <= 1'b1;
      end else begin
         done_r <= 1'b0;
         div_r  <= half ? 5'h00 : div_r + 5'h01;
         case (st_r)
            E_IDLE: begin
               div_r <= 5'h00;
               // a clock parked high after a byte falls here
               sck_r <= 1'b0;
               if (go) begin
                  // select held low from first byte onward
                  csn_r <= 1'b0;
                  sdo_r <= tx[7];  // moves with the fall
                  sh_r  <= tx;
                  lst_r <= last;
                  bit_r <= 3'h0;
                  st_r  <= E_LO;
               end
            end
            E_LO: begin
               if (half) begin
                  sck_r <= 1'b1;
                  rx_r  <= {rx_r[6:0], sdi};
                  st_r  <= E_HI;
               end
            end
            E_HI: begin
               if (early && (bit_r == 3'h7) && !lst_r) begin
                  // more bytes follow: go idle a cycle early with the
                  // clock still high, so the next msb rides the fall
                  done_r <= 1'b1;
                  st_r   <= E_IDLE;
               end else if (half) begin
                  sck_r <= 1'b0;
                  if (bit_r == 3'h7) begin
                     done_r <= 1'b1;
                     st_r   <= E_CSH;
                  end else begin
                     bit_r <= bit_r + 3'h1;
                     sh_r  <= {sh_r[6:0], 1'b0};
                     sdo_r <= sh_r[6];  // change on fall
                     st_r  <= E_LO;
                  end
               end
            end
            E_CSH: begin
               // hold time after last fall, then release
               if (half) begin
                  csn_r <= 1'b1;
                  st_r  <= E_IDLE;
               end
            end
            default: st_r <= E_IDLE;
         endcase
      end
   end
endmodule

// ==== core/secl_loader.v ====
/*
 * serial configuration loader top: after reset reads an image from a
 * serial memory and issues record writes to the configuration block;
 * afterwards serves single byte reads and writes requested by logic.
 * assumes cfg_ready and the request inputs are on ref_clk; the memory
 * output pin is asynchronous.
 */
`timescale 1ns/10ps
`include "secl_defines.vh"
module secl_loader #(
   parameter [15:0] ID_CODE = 16'h5A3C  // arbitrary value
) (
   input  wire        ref_clk,
   input  wire        rst,
   output wire        serial_memory_clock,
   output wire        serial_out_to_memory,
   input  wire        serial_in_from_memory,
   output wire        mem_select_n,
   output reg         cfg_valid_r,
   input  wire        cfg_ready,
   output reg  [11:0] cfg_addr_r,
   output reg  [3:0]  cfg_be_r,
   output reg  [31:0] cfg_data_r,
   output reg         load_done_r,
   output reg  [1:0]  addr_mode_r,
   input  wire        wr_req,
   input  wire        rd_req,
   input  wire [15:0] sw_addr,
   input  wire [7:0]  sw_wdata,
   output reg  [7:0]  sw_rdata_r,
   output reg         sw_rvalid_r,
   output reg         sw_busy_r
);
   // phases
   localparam P_ID9   = 4'h0;
   localparam P_ID16  = 4'h1;
   localparam P_CNT   = 4'h2;
   localparam P_REC   = 4'h3;
   localparam P_IDLE  = 4'h4;
   localparam P_WREN  = 4'h5;
   localparam P_WRITE = 4'h6;
   localparam P_RDSR  = 4'h7;
   localparam P_READ  = 4'h8;
   // instruction steps
   localparam T_IDLE  = 2'h0;
   localparam T_HDR   = 2'h1;
   localparam T_BODY  = 2'h2;
   localparam T_WAIT  = 2'h3;

   reg  [3:0]  ph_r;      // loader phase
   reg  [1:0]  st_r;      // instruction step
   reg  [1:0]  hidx_r;    // header byte index
   reg  [15:0] addr_r;    // instruction start address
   reg  [16:0] left_r;    // body bytes left, fixed length phases
   reg  [16:0] iss_r;     // record bytes issued
   reg  [2:0]  gb_r;      // issue position within record
   reg  [2:0]  rb_r;      // receive position within record
   reg         bflag_r;   // byte in flight belongs to body
   reg  [15:0] sh_r;      // received bytes, low first
   reg  [15:0] cnt_r;     // image byte count
   reg  [39:0] rec_r;     // partial record
   reg         mode16_r;  // sixteen-bit addressing
   reg         recs_r;    // all records pushed
   reg         wr_sel_r;  // pending software op is a write
   reg  [7:0]  wdat_r;    // software write data
   reg         sync1_r;   // input synchroniser stage one
   reg         sync2_r;   // input synchroniser stage two

   wire        eng_rdy;
   wire        eng_done;
   wire [7:0]  eng_rx;
   reg         eng_go;
   reg  [7:0]  eng_tx;
   reg         eng_last;
   wire        fin_valid;
   wire        fin_ready;
   wire        fout_valid;
   wire        fout_pop;
   wire [47:0] fout_data;
   wire        body_done;
   wire        rec_last;
   wire        hdr_end;

   // opcode per phase
   function [7:0] op_of;
      input [3:0] ph;
      begin
         case (ph)
            P_WREN:  op_of = `SECL_OP_WREN;
            P_WRITE: op_of = `SECL_OP_WRITE;
            P_RDSR:  op_of = `SECL_OP_RDSR;
            default: op_of = `SECL_OP_READ;
         endcase
      end
   endfunction

   // header length: opcode only, or opcode plus one or two address bytes
   function [1:0] hlen_of;
      input [3:0] ph;
      input       m16;
      begin
         if (ph == P_WREN || ph == P_RDSR)
            hlen_of = 2'h1;
         else
            hlen_of = m16 ? 2'h3 : 2'h2;  // one byte in 9-bit
      end
   endfunction

   // header byte by index
   function [7:0] hdr_of;
      input [3:0]  ph;
      input [15:0] a;
      input [1:0]  idx;
      input        m16;
      reg   [7:0]  op;
      begin
         op = op_of(ph);
         if (idx == 2'h0) begin
            hdr_of = op;
            // address bit 8 rides in opcode bit 3
            if (!m16 && (ph == P_WRITE || ph != P_WREN && ph != P_RDSR))
               hdr_of[`SECL_OP_A8_POS] = a[8];
         end else if (idx == 2'h1 && m16)
            hdr_of = a[15:8];
         else
            hdr_of = a[7:0];
      end
   endfunction

   // memory output pin: two flops before any use
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= serial_in_from_memory;
         sync2_r <= sync1_r;
      end
   end

   // serial clock divided down from ref_clk inside shifter
   secl_shift u_shift (
      .ref_clk (ref_clk),
      .rst     (rst),
      .go      (eng_go),
      .tx      (eng_tx),
      .last    (eng_last),
      .sdi     (sync2_r),
      .rdy     (eng_rdy),
      .done_r  (eng_done),
      .rx_r    (eng_rx),
      .sck_r   (serial_memory_clock),
      .sdo_r   (serial_out_to_memory),
      .csn_r   (mem_select_n)
   );

   assign body_done = eng_done & bflag_r;
   // stop at the record end that reaches the count
   assign rec_last  = (gb_r == `SECL_REC_LAST) &&
                      ((iss_r + 17'h00001) >= {1'b0, cnt_r});
   assign hdr_end   = (hidx_r == hlen_of(ph_r, mode16_r) - 2'h1);
   // complete record pushed on its sixth byte
   assign fin_valid = body_done && (ph_r == P_REC) &&
                      (rb_r == `SECL_REC_LAST);

   // byte request to the shifter
   always @* begin
      eng_go   = 1'b0;
      eng_tx   = 8'h00;
      eng_last = 1'b0;
      if (st_r == T_HDR) begin
         eng_go   = eng_rdy;
         eng_tx   = hdr_of(ph_r, addr_r, hidx_r, mode16_r);
         eng_last = hdr_end && (ph_r == P_WREN);
      end else if (st_r == T_BODY) begin
         if (ph_r == P_REC) begin
            // record start waits for room so no record is lost
            eng_go   = eng_rdy &
                       ((gb_r != 3'h0) | (fin_ready & ~eng_done));
            eng_last = rec_last;
         end else begin
            eng_go   = eng_rdy;
            eng_last = (left_r == 17'h00001);
            eng_tx   = (ph_r == P_WRITE) ? wdat_r : 8'h00;
         end
      end
   end

   // record buffer toward the configuration block
   secl_fifo #(
      .W  (`SECL_FIFO_W),
      .D  (`SECL_FIFO_D),
      .AW (`SECL_FIFO_AW)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (fin_valid),
      .in_ready  (fin_ready),
      .in_data   ({eng_rx, rec_r}),
      .out_valid (fout_valid),
      .out_ready (fout_pop),
      .out_data  (fout_data)
   );

   assign fout_pop = fout_valid & (~cfg_valid_r | cfg_ready);

   // output stage: held until the configuration block takes it
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_valid_r <= 1'b0;
         cfg_addr_r  <= 12'h000;
         cfg_be_r    <= 4'h0;
         cfg_data_r  <= 32'h00000000;
      end else if (fout_pop) begin
         cfg_valid_r <= 1'b1;
         cfg_addr_r  <= {fout_data[11:8], fout_data[7:0]};
         cfg_be_r    <= fout_data[15:12];
         cfg_data_r  <= fout_data[47:16];
      end else if (cfg_ready) begin
         cfg_valid_r <= 1'b0;
      end
   end

   // loader sequence and software operations
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ph_r        <= P_ID9;
         st_r        <= T_IDLE;
         hidx_r      <= 2'h0;
         addr_r      <= 16'h0000;
         left_r      <= 17'h00000;
         iss_r       <= 17'h00000;
         gb_r        <= 3'h0;
         rb_r        <= 3'h0;
         bflag_r     <= 1'b0;
         sh_r        <= 16'h0000;
         cnt_r       <= 16'h0000;
         rec_r       <= 40'h0000000000;
         mode16_r    <= 1'b0;
         recs_r      <= 1'b0;
         wr_sel_r    <= 1'b0;
         wdat_r      <= 8'h00;
         load_done_r <= 1'b0;
         addr_mode_r <= `SECL_MODE_NONE;
         sw_rdata_r  <= 8'h00;
         sw_rvalid_r <= 1'b0;
         sw_busy_r   <= 1'b0;
      end else begin
         sw_rvalid_r <= 1'b0;
         // done once all records have been taken by the configuration block
         if (recs_r && !fout_valid && !cfg_valid_r)
            load_done_r <= 1'b1;
         // received body bytes
         if (body_done) begin
            sh_r <= {eng_rx, sh_r[15:8]};  // low byte first
            if (ph_r == P_REC) begin
               rec_r <= {eng_rx, rec_r[39:8]};
               rb_r  <= (rb_r == `SECL_REC_LAST) ? 3'h0 : rb_r + 3'h1;
            end
         end
         if (eng_go)
            bflag_r <= (st_r == T_BODY);
         case (st_r)
            T_IDLE: begin
               hidx_r <= 2'h0;
               if (ph_r != P_IDLE) begin
                  st_r <= T_HDR;
                  case (ph_r)
                     P_ID9, P_ID16: begin
                        addr_r <= `SECL_IMG_ID;
                        left_r <= 17'h00002;
                     end
                     P_CNT: begin
                        addr_r <= `SECL_IMG_CNT;
                        left_r <= 17'h00002;
                     end
                     P_REC: begin
                        addr_r <= `SECL_IMG_REC;
                        iss_r  <= 17'h00000;
                        gb_r   <= 3'h0;
                        rb_r   <= 3'h0;
                     end
                     default: left_r <= 17'h00001;
                  endcase
               end else if (load_done_r && (wr_req || rd_req)) begin
                  // requests only taken when idle, otherwise ignored
                  sw_busy_r <= 1'b1;
                  wr_sel_r  <= wr_req;
                  wdat_r    <= sw_wdata;
                  addr_r    <= sw_addr;
                  left_r    <= 17'h00001;
                  ph_r      <= wr_req ? P_WREN : P_READ;
               end
            end
            T_HDR: begin
               if (eng_go) begin
                  hidx_r <= hidx_r + 2'h1;
                  if (hdr_end)
                     st_r <= (ph_r == P_WREN) ? T_WAIT : T_BODY;
               end
            end
            T_BODY: begin
               if (eng_go) begin
                  if (ph_r == P_REC) begin
                     // back to back, six bytes each
                     iss_r <= iss_r + 17'h00001;
                     gb_r  <= (gb_r == `SECL_REC_LAST) ? 3'h0 :
                              gb_r + 3'h1;
                     if (rec_last)
                        st_r <= T_WAIT;
                  end else begin
                     left_r <= left_r - 17'h00001;
                     if (left_r == 17'h00001)
                        st_r <= T_WAIT;
                  end
               end
            end
            T_WAIT: begin
               // decide once the select is released
               if (eng_rdy && !eng_done) begin
                  st_r <= T_IDLE;
                  case (ph_r)
                     P_ID9: begin
                        if (sh_r == ID_CODE) begin
                           addr_mode_r <= `SECL_MODE_9;
                           ph_r        <= P_CNT;
                        end else begin
                           mode16_r <= 1'b1;
                           ph_r     <= P_ID16;
                        end
                     end
                     P_ID16: begin
                        if (sh_r == ID_CODE) begin
                           addr_mode_r <= `SECL_MODE_16;
                           ph_r        <= P_CNT;
                        end else begin
                           addr_mode_r <= `SECL_MODE_NONE;
                           recs_r      <= 1'b1;
                           ph_r        <= P_IDLE;
                        end
                     end
                     P_CNT: begin
                        cnt_r <= sh_r;
                        if (sh_r == 16'h0000) begin
                           recs_r <= 1'b1;
                           ph_r   <= P_IDLE;
                        end else
                           ph_r <= P_REC;
                     end
                     P_REC: begin
                        recs_r <= 1'b1;
                        ph_r   <= P_IDLE;
                     end
                     P_WREN:  ph_r <= P_WRITE;
                     P_WRITE: ph_r <= P_RDSR;
                     P_RDSR: begin
                        if (sh_r[8])
                           ph_r <= P_RDSR;
                        else begin
                           ph_r      <= P_IDLE;
                           sw_busy_r <= 1'b0;
                        end
                     end
                     P_READ: begin
                        sw_rdata_r  <= sh_r[15:8];
                        sw_rvalid_r <= 1'b1;
                        sw_busy_r   <= 1'b0;
                        ph_r        <= P_IDLE;
                     end
                     default: ph_r <= P_IDLE;
                  endcase
               end
            end
            default: st_r <= T_IDLE;
         endcase
      end
   end
endmodule

// ==== tb/secl_loader_checker.sv ====
/* assertion checker for the serial configuration loader top.
   assumes a bind to secl_loader; one clock, async high reset. */
`timescale 1ns/10ps
module secl_loader_checker (
   input logic        ref_clk,
   input logic        rst,
   input logic        serial_memory_clock,
   input logic        serial_out_to_memory,
   input logic        mem_select_n,
   input logic        cfg_valid_r,
   input logic        cfg_ready,
   input logic [11:0] cfg_addr_r,
   input logic [3:0]  cfg_be_r,
   input logic [31:0] cfg_data_r,
   input logic        load_done_r,
   input logic [1:0]  addr_mode_r,
   input logic        wr_req,
   input logic        sw_rvalid_r,
   input logic        sw_busy_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_sck_half: assert property (
      $rose(serial_memory_clock) |-> ##12 $fell(serial_memory_clock))
      else $error("serial clock high time wrong");
   chk_first_edge: assert property (
      $fell(mem_select_n) |-> ##12 $rose(serial_memory_clock))
      else $error("first clock not 12 after select");
   chk_idle_clock: assert property (
      mem_select_n |-> !serial_memory_clock)
      else $error("clock moves while deselected");
   chk_out_on_fall: assert property (
      !mem_select_n && $past(!mem_select_n) &&
      $changed(serial_out_to_memory) |-> $fell(serial_memory_clock))
      else $error("data changed off falling clock");
   chk_rec_hold: assert property (
      cfg_valid_r && !cfg_ready |=> cfg_valid_r && $stable(cfg_addr_r) &&
      $stable(cfg_be_r) && $stable(cfg_data_r))
      else $error("record dropped or changed while stalled");
   chk_done_sticky: assert property (
      load_done_r |=> load_done_r)
      else $error("load done fell");
   chk_done_quiet: assert property (
      load_done_r |-> !cfg_valid_r)
      else $error("record offered after done");
   chk_mode_frozen: assert property (
      load_done_r && $past(load_done_r) |->
      $stable(addr_mode_r) && addr_mode_r != 2'h3)
      else $error("address mode moved after done");
   chk_busy_start: assert property (
      wr_req && load_done_r && !sw_busy_r |=> sw_busy_r)
      else $error("write request not taken");
   chk_rvalid_end: assert property (
      sw_rvalid_r |-> $fell(sw_busy_r) ##1 !sw_rvalid_r)
      else $error("read result not a pulse at busy end");
   // main scenarios reached
   cover property (cfg_valid_r && !cfg_ready);
   cover property ($rose(load_done_r) && addr_mode_r == 2'h2);
   cover property (sw_rvalid_r);
endmodule
bind secl_loader secl_loader_checker chk_u (.ref_clk(ref_clk), .rst(rst),
   .serial_memory_clock(serial_memory_clock), .mem_select_n(mem_select_n),
   .serial_out_to_memory(serial_out_to_memory), .cfg_ready(cfg_ready),
   .cfg_valid_r(cfg_valid_r), .cfg_addr_r(cfg_addr_r), .cfg_be_r(cfg_be_r),
   .cfg_data_r(cfg_data_r), .load_done_r(load_done_r), .wr_req(wr_req),
   .addr_mode_r(addr_mode_r), .sw_rvalid_r(sw_rvalid_r),
   .sw_busy_r(sw_busy_r));

// ==== tb/secl_mem_model.sv ====
/* behavioural serial memory, mode 0, one or two address bytes.
   assumes the bench presets mem and picks the address mode. */
`timescale 1ns/10ps
module secl_mem_model (
   input  logic sck,
   input  logic csn,
   input  logic din,
   output logic dout = 1'b0,
   input  logic a16
);
   logic [7:0]  mem [0:65535]; // image
   logic [7:0]  op, sh;        // opcode, shift in
   logic [15:0] adr;           // byte address
   logic        wel = 1'b0;    // write enabled
   int          cnt, k, pend = 0; // edges, out bit, busy polls
   always @(negedge csn) cnt = 0;
   // capture on rising clock
   always @(posedge sck) if (!csn) begin
      sh = {sh[6:0], din};
      cnt++;
      if (cnt == 8) begin
         op = sh & ~{4'h0, !a16, 3'h0};
         adr = {7'h0, sh[3] & !a16, 8'h0};
         wel |= op == 8'h06;
      end
      if (cnt > 8 && cnt <= 8 + 8 * (1 + a16) && cnt % 8 == 0)
         adr = a16 ? {adr[7:0], sh} : {adr[15:8], sh};
      if (op == 8'h02 && wel && cnt == 16 + 8 * (1 + a16)) begin
         mem[adr] = sh;
         wel = 1'b0;
         pend = 2; // write cycle lasts two status polls
      end
   end
   // drive on falling clock, toggle outside data
   always @(negedge sck) if (!csn) begin
      k = cnt - (op == 8'h05 ? 8 : 8 + 8 * (1 + a16));
      if (k >= 0 && cnt >= 8 && (op == 8'h03 || op == 8'h05))
         dout = op == 8'h05 ? (pend != 0) & (k % 8 == 7)
                            : mem[16'(adr + k / 8)][7 - k % 8];
      else
         dout = ~dout;
   end
   // released line shows no stale bit
   always @(posedge csn) begin
      dout = ~dout;
      if (op == 8'h05 && pend > 0) pend--;
   end
endmodule

// ==== tb/secl_loader_bench.sv ====
/* self-checking bench of the serial configuration loader: loads in both
   address modes, absent memory, software write and read.
   assumes the behavioural memory model beside the design. */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fails++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module secl_loader_bench;
   localparam logic [15:0] ID_VAL = 16'h1E96; // arbitrary value
   logic        ref_clk = 1'b0, rst = 1'b1, cfg_ready = 1'b0;
   logic        wr_req = 1'b0, rd_req = 1'b0, a16 = 1'b0, stall = 1'b0;
   logic [15:0] sw_addr = 16'h0000;
   logic [7:0]  sw_wdata = 8'h00;
   logic [31:0] lfsr = 32'hCCD3289C; // fixed seed
   int          fails = 0, total_checks = 0, nrec = 0;
   wire         sck, sdo, sdi, csn, cfg_valid_r, load_done_r;
   wire         sw_rvalid_r, sw_busy_r;
   wire [11:0]  cfg_addr_r;
   wire [3:0]   cfg_be_r;
   wire [31:0]  cfg_data_r;
   wire [1:0]   addr_mode_r;
   wire [7:0]   sw_rdata_r;
   wire [47:0]  rec_seen = {cfg_addr_r, cfg_be_r, cfg_data_r};
   secl_loader #(.ID_CODE(ID_VAL)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .serial_memory_clock(sck), .serial_out_to_memory(sdo),
      .serial_in_from_memory(sdi), .mem_select_n(csn),
      .cfg_valid_r(cfg_valid_r), .cfg_ready(cfg_ready),
      .cfg_addr_r(cfg_addr_r), .cfg_be_r(cfg_be_r), .cfg_data_r(cfg_data_r),
      .load_done_r(load_done_r), .addr_mode_r(addr_mode_r),
      .wr_req(wr_req), .rd_req(rd_req), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_rdata_r(sw_rdata_r),
      .sw_rvalid_r(sw_rvalid_r), .sw_busy_r(sw_busy_r));
   secl_mem_model mem_u (.sck(sck), .csn(csn), .din(sdo), .dout(sdi),
      .a16(a16));
   function logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // expected record k: address, enables, data low byte first
   function logic [47:0] exp_rec(int k);
      int b;
      b = 4 + 6 * k;
      return {mem_u.mem[b+1][3:0], mem_u.mem[b], mem_u.mem[b+1][7:4],
         mem_u.mem[b+5], mem_u.mem[b+4], mem_u.mem[b+3], mem_u.mem[b+2]};
   endfunction
   initial forever #2.5 ref_clk = ~ref_clk;
   // random back-pressure, held off to fill the buffer
   always @(negedge ref_clk) cfg_ready <= !stall && rnd() % 3 != 0;
   // each accepted record against the image
   always @(posedge ref_clk) if (!rst && cfg_valid_r && cfg_ready) begin
      `CHK("rec", exp_rec(nrec), rec_seen)
      nrec++;
   end
   task tally_and_finish();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // a bounded wait that ran out closes the run
   task bound(int i, int lim);
      if (i >= lim) begin
         fails++;
         tally_and_finish();
      end
   endtask
   // reset, load an image, compare the outcome
   task load(logic m16, logic [15:0] idv, logic [15:0] cnt, int erec,
             logic [1:0] emode, int st);
      int i;
      {mem_u.mem[1], mem_u.mem[0]} = idv;
      {mem_u.mem[3], mem_u.mem[2]} = cnt;
      a16 = m16;
      nrec = 0;
      rst = 1'b1;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      for (i = 0; i < 60000 && load_done_r !== 1'b1; i++) begin
         stall <= i < st;
         @(negedge ref_clk);
      end
      bound(i, 60000);
      stall <= 1'b0;
      `CHK("mode", emode, addr_mode_r)
      `CHK("records", erec, nrec)
   endtask
   // one software access, then memory or read data compared
   task sw(logic wr, logic [15:0] a);
      int i;
      sw_addr = a;
      sw_wdata = ~mem_u.mem[a];
      wr_req = wr;
      rd_req = !wr;
      @(negedge ref_clk);
      wr_req = 1'b0;
      rd_req = 1'b0;
      `CHK("busy", 1'b1, sw_busy_r)
      for (i = 0; i < 20000 && sw_busy_r !== 1'b0; i++) @(negedge ref_clk);
      bound(i, 20000);
      if (wr)
         `CHK("wbyte", sw_wdata, mem_u.mem[a])
      else
         `CHK("rbyte", mem_u.mem[a], sw_rdata_r)
   endtask
   initial begin
      for (int j = 0; j < 65536; j++) mem_u.mem[j] = 8'(rnd());
      // nine-bit, 115 rounds up to 20 records, buffer filled
      load(1'b0, ID_VAL, 16'h0073, 20, 2'h1, 24000);
      sw(1'b1, 16'h01A5);
      sw(1'b0, 16'h01A5);
      // sixteen-bit, exact multiple, top of the space
      load(1'b1, ID_VAL, 16'h000C, 2, 2'h2, 0);
      sw(1'b0, 16'hFFFA);
      sw(1'b1, 16'hFFFF);
      // wrong code in both modes: no memory
      load(1'b0, ~ID_VAL, 16'h0006, 0, 2'h0, 0);
      tally_and_finish();
   end
endmodule
